// File: inc/hvif_defines.vh
// constants shared by the high-voltage indirect register interface
`ifndef HVIF_DEFINES_VH
`define HVIF_DEFINES_VH

// ----------------------------------------------------------------------
// register map
// ----------------------------------------------------------------------
`define HVIF_CMD_ADDR    32'hffff0804
`define HVIF_DAT_ADDR    32'hffff080c
`define HVIF_ADDR_W      32
`define HVIF_DAT_W       12

// ----------------------------------------------------------------------
// command codes
// ----------------------------------------------------------------------
`define HVIF_CMD_RD_CFG0 8'h00
`define HVIF_CMD_RD_CFG1 8'h01
`define HVIF_CMD_RD_STAT 8'h02
`define HVIF_CMD_RD_MON  8'h03
`define HVIF_CMD_WR_CFG0 8'h08
`define HVIF_CMD_WR_CFG1 8'h09

// ----------------------------------------------------------------------
// field layout
// ----------------------------------------------------------------------
`define HVIF_BIT_BUSY    0
`define HVIF_BIT_RDOK    1
`define HVIF_BIT_TXOK    2
`define HVIF_DAT_LO      7
`define HVIF_DAT_CMD_HI  11
`define HVIF_DAT_CMD_LO  8
`define HVIF_CODE_W      4
`define HVIF_BYTE_W      8
`define HVIF_DAT_RST     12'h000
`define HVIF_FLAG_RST    1'b0

// ----------------------------------------------------------------------
// link framing and timing
// ----------------------------------------------------------------------
`define HVIF_SEND_BITS   12
`define HVIF_RESP_BITS   9
`define HVIF_CLK_HZ      125000000
`define HVIF_SCLK_HZ     2560000
`define HVIF_HALF_CYC    (`HVIF_CLK_HZ / (2 * `HVIF_SCLK_HZ))
`define HVIF_CLK_NS      8
`define HVIF_LAT_NS      10000
`define HVIF_LAT_CYC     (`HVIF_LAT_NS / `HVIF_CLK_NS)

`endif

// File: core/hvif_sync.v
// two flip-flop synchroniser for the link data input
`default_nettype none

module hvif_sync
(
	input  wire mclk,
	input  wire rst_n,
	input  wire asyncIn,
	output reg  syncOut
);

	reg meta_reg;

	// first stage is read only by the second
	always @(posedge mclk)
	begin
		if (!rst_n)
		begin
			meta_reg <= 1'b0;
			syncOut  <= 1'b0;
		end
		else
		begin
			meta_reg <= asyncIn;
			syncOut  <= meta_reg;
		end
	end

endmodule // hvif_sync

`default_nettype wire

// File: core/hvif_sclk_gen.v
// serial clock divider with edge ticks for the link
`default_nettype none

module hvif_sclk_gen
#(
	parameter HALF_CYC = 24
)
(
	input  wire mclk,
	input  wire rst_n,
	input  wire run,
	output reg  sclk,
	output wire riseTick,
	output wire fallTick
);

	reg  [7:0] cnt_reg;
	wire       wrap;

	assign wrap     = run && (cnt_reg == HALF_CYC[7:0] - 8'h01);
	assign riseTick = wrap && !sclk;
	assign fallTick = wrap && sclk;

	// clock idles low and restarts from a fresh low phase each frame
	always @(posedge mclk)
	begin
		if (!rst_n || !run)
		begin
			cnt_reg <= 8'h00;
			sclk    <= 1'b0;
		end
		else if (wrap)
		begin
			cnt_reg <= 8'h00;
			sclk    <= !sclk;
		end
		else
		begin
			cnt_reg <= cnt_reg + 8'h01;
		end
	end

endmodule // hvif_sclk_gen

`default_nettype wire

// File: core/hvif_core.v
// command interpreter for the high-voltage indirect registers
//
// Overview of operation
// - codes 00-03 fetch indirect register into data
// - codes 08/09 send data byte to config
// - one byte per command; indirect only
// - two-wire link, data plus 2.56 MHz clock; the mclk divide by 48 gives about 2.60 MHz
// - command or write data delivered within 10 us
// - read value lands in data within 10 us
// - command read bit 0 is busy
// - bit 2 is transmit success flag
// - bit 1 is read success flag
// - flags valid only while busy is low
// - 8-bit command register, bits 7-3 reserved
// - 12-bit data, bits 11-8 show command
`include "hvif_defines.vh"
`default_nettype none

module hvif_core
#(
	parameter HALF_CYC = `HVIF_HALF_CYC,
	parameter LAT_CYC  = `HVIF_LAT_CYC
)
(
	input  wire        mclk,
	input  wire        rst_n,
	input  wire [31:0] regAddr,
	input  wire        regWrEn,
	input  wire        regRdEn,
	input  wire [11:0] regWrData,
	output reg  [11:0] regRdData,
	output wire        hvSclk,
	output reg         hvDataOut,
	output reg         hvDataOe,
	input  wire        hvDataIn
);

	// ------------------------------------------------------------------
	// states
	// ------------------------------------------------------------------
	localparam [2:0] ST_IDLE = 3'b000;
	localparam [2:0] ST_SEND = 3'b001;
	localparam [2:0] ST_TURN = 3'b010;
	localparam [2:0] ST_RECV = 3'b011;
	localparam [2:0] ST_DONE = 3'b100;

	// ------------------------------------------------------------------
	// declarations
	// ------------------------------------------------------------------
	reg  [2:0]  state_reg;
	reg  [2:0]  state_next;
	reg  [11:0] shift_reg;
	reg  [11:0] shift_next;
	reg  [3:0]  bitCnt_reg;
	reg  [3:0]  bitCnt_next;
	reg  [10:0] wdog_reg;
	reg  [10:0] wdog_next;
	reg  [3:0]  code_reg;
	reg  [3:0]  code_next;
	reg         isRead_reg;
	reg         isRead_next;
	reg         busy_reg;
	reg         busy_next;
	reg         rdOk_reg;
	reg         rdOk_next;
	reg         txOk_reg;
	reg         txOk_next;
	reg  [11:0] data_reg;
	reg  [11:0] data_next;
	reg         dout_next;
	reg         oe_next;
	reg  [11:0] rdData_next;
	wire        cmdWrite;
	wire        datWrite;
	wire        cmdIsRead;
	wire        cmdIsWrite;
	wire        run;
	wire        fallTick;
	wire        dinSync;
	wire        timeout;
	wire [7:0]  wrCode;

	// ------------------------------------------------------------------
	// register decode
	// ------------------------------------------------------------------
	assign cmdWrite = regWrEn && (regAddr == `HVIF_CMD_ADDR);
	assign datWrite = regWrEn && (regAddr == `HVIF_DAT_ADDR);
	assign wrCode   = regWrData[`HVIF_DAT_LO:0];

	// only the six documented codes start link traffic
	assign cmdIsRead  = (wrCode == `HVIF_CMD_RD_CFG0) || (wrCode == `HVIF_CMD_RD_CFG1) ||
		(wrCode == `HVIF_CMD_RD_STAT) || (wrCode == `HVIF_CMD_RD_MON);
	assign cmdIsWrite = (wrCode == `HVIF_CMD_WR_CFG0) ||
		(wrCode == `HVIF_CMD_WR_CFG1);

	// the link runs only while a frame is in flight
	assign run     = (state_reg == ST_SEND) || (state_reg == ST_TURN) ||
		(state_reg == ST_RECV);
	// bounds every frame so busy never outlives the latency budget
	assign timeout = run && (wdog_reg == LAT_CYC[10:0] - 11'h001);

	// ------------------------------------------------------------------
	// link clock and input synchroniser
	// ------------------------------------------------------------------
	// divided from mclk, so no second clock domain exists here
	hvif_sclk_gen #(
		.HALF_CYC (HALF_CYC)
	) u_sclk (
		.mclk     (mclk),
		.rst_n    (rst_n),
		.run      (run),
		.sclk     (hvSclk),
		.riseTick (),
		.fallTick (fallTick)
	);

	hvif_sync u_din (
		.mclk    (mclk),
		.rst_n   (rst_n),
		.asyncIn (hvDataIn),
		.syncOut (dinSync)
	);

	// ------------------------------------------------------------------
	// frame sequencer
	// ------------------------------------------------------------------
	// frame: 12 bits out (code, byte), one turnaround period, 8 bits
	// back plus an ack bit; a silent far end reads as a failed ack
	always @*
	begin
		state_next  = state_reg;
		shift_next  = shift_reg;
		bitCnt_next = bitCnt_reg;
		wdog_next   = wdog_reg;
		code_next   = code_reg;
		isRead_next = isRead_reg;
		busy_next   = busy_reg;
		rdOk_next   = rdOk_reg;
		txOk_next   = txOk_reg;
		data_next   = data_reg;
		dout_next   = hvDataOut;
		oe_next     = hvDataOe;
		if (run)
		begin
			wdog_next = wdog_reg + 11'h001;
		end
		case (state_reg)
			ST_IDLE:
			begin
				// software byte writes land only while idle
				if (datWrite)
				begin
					data_next[`HVIF_DAT_LO:0] = regWrData[`HVIF_DAT_LO:0];
				end
				if (cmdWrite)
				begin
					busy_next = 1'b1;
					wdog_next = 11'h000;
					if (cmdIsRead || cmdIsWrite)
					begin
						// one code and one byte per frame
						shift_next  = {wrCode[`HVIF_CODE_W-1:0],
							data_reg[`HVIF_DAT_LO:0]};
						code_next   = wrCode[`HVIF_CODE_W-1:0];
						isRead_next = cmdIsRead;
						// transmit flag starts as failure, read flag too on reads only, so a cut frame never shows stale success
						txOk_next   = 1'b0;
						rdOk_next   = cmdIsRead ? 1'b0 : rdOk_reg;
						data_next[`HVIF_DAT_CMD_HI:`HVIF_DAT_CMD_LO] =
							wrCode[`HVIF_CODE_W-1:0];
						bitCnt_next = 4'h0;
						oe_next     = 1'b1;
						dout_next   = wrCode[`HVIF_CODE_W-1];
						state_next  = ST_SEND;
					end
					else
					begin
						state_next = ST_DONE;
					end
				end
			end
			ST_SEND:
			begin
				if (timeout)
				begin
					oe_next    = 1'b0;
					txOk_next  = 1'b0;
					state_next = ST_DONE;
				end
				else if (fallTick)
				begin
					// next bit changes on the falling edge, far end samples on rise
					if (bitCnt_reg == `HVIF_SEND_BITS - 1)
					begin
						oe_next     = 1'b0;
						dout_next   = 1'b0;
						bitCnt_next = 4'h0;
						state_next  = ST_TURN;
					end
					else
					begin
						shift_next  = {shift_reg[10:0], 1'b0};
						dout_next   = shift_reg[`HVIF_SEND_BITS-2];
						bitCnt_next = bitCnt_reg + 4'h1;
					end
				end
			end
			ST_TURN:
			begin
				// one idle period avoids both ends driving the data wire
				if (timeout)
				begin
					txOk_next  = 1'b0;
					state_next = ST_DONE;
				end
				else if (fallTick)
				begin
					state_next = ST_RECV;
				end
			end
			ST_RECV:
			begin
				if (timeout)
				begin
					txOk_next = 1'b0;
					if (isRead_reg)
					begin
						rdOk_next = 1'b0;
					end
					state_next = ST_DONE;
				end
				else if (fallTick)
				begin
					// sampled at the end of the high phase
					shift_next = {shift_reg[10:0], dinSync};
					if (bitCnt_reg == `HVIF_RESP_BITS - 1)
					begin
						txOk_next = dinSync;
						if (isRead_reg)
						begin
							rdOk_next = dinSync;
							if (dinSync)
							begin
								data_next = {code_reg, shift_reg[`HVIF_DAT_LO:0]};
							end
						end
						state_next = ST_DONE;
					end
					else
					begin
						bitCnt_next = bitCnt_reg + 4'h1;
					end
				end
			end
			ST_DONE:
			begin
				// flags were settled a cycle earlier, so busy falls last
				busy_next  = 1'b0;
				state_next = ST_IDLE;
			end
			default:
			begin
				busy_next  = 1'b0;
				oe_next    = 1'b0;
				state_next = ST_IDLE;
			end
		endcase
	end

	// ------------------------------------------------------------------
	// read data path
	// ------------------------------------------------------------------
	// reserved bits of the status byte read as zero
	always @*
	begin
		rdData_next = 12'h000;
		if (regRdEn && (regAddr == `HVIF_CMD_ADDR))
		begin
			rdData_next[`HVIF_BIT_BUSY] = busy_reg;
			rdData_next[`HVIF_BIT_RDOK] = rdOk_reg;
			rdData_next[`HVIF_BIT_TXOK] = txOk_reg;
		end
		else if (regRdEn && (regAddr == `HVIF_DAT_ADDR))
		begin
			rdData_next = data_reg;
		end
	end

	// ------------------------------------------------------------------
	// state registers
	// ------------------------------------------------------------------
	always @(posedge mclk)
	begin
		if (!rst_n)
		begin
			state_reg  <= ST_IDLE;
			shift_reg  <= 12'h000;
			bitCnt_reg <= 4'h0;
			wdog_reg   <= 11'h000;
			code_reg   <= 4'h0;
			isRead_reg <= 1'b0;
			busy_reg   <= 1'b0;
			rdOk_reg   <= `HVIF_FLAG_RST;
			txOk_reg   <= `HVIF_FLAG_RST;
			data_reg   <= `HVIF_DAT_RST;
			hvDataOut  <= 1'b0;
			hvDataOe   <= 1'b0;
			regRdData  <= 12'h000;
		end
		else
		begin
			state_reg  <= state_next;
			shift_reg  <= shift_next;
			bitCnt_reg <= bitCnt_next;
			wdog_reg   <= wdog_next;
			code_reg   <= code_next;
			isRead_reg <= isRead_next;
			busy_reg   <= busy_next;
			rdOk_reg   <= rdOk_next;
			txOk_reg   <= txOk_next;
			data_reg   <= data_next;
			hvDataOut  <= dout_next;
			hvDataOe   <= oe_next;
			regRdData  <= rdData_next;
		end
	end

endmodule // hvif_core

`default_nettype wire

// File: tb/hvif_far_end.sv
// far-end register logic model for the high-voltage link
`default_nettype none
module hvif_far_end
#(
	parameter logic [7:0] STAT_VAL = 8'h5a,
	parameter logic [7:0] MON_VAL  = 8'hc3
)
(
	input  wire logic sclk,
	input  wire logic din,
	input  wire logic oe,
	input  wire logic ackOk,
	output var  logic dout
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [7:0]  cfg0 = 8'h00;
	logic [7:0]  cfg1 = 8'h00;
	logic [11:0] shIn = 12'h000;
	logic [8:0]  shOut = 9'h000;
	int          falls = 0;
	initial dout = 1'b0;
	// ----
	// frame handling
	// ----
	// command bits are taken on rising clock while the core drives
	always @(posedge sclk)
		if (oe)
			shIn <= {shIn[10:0], din};
	always @(posedge oe)
		falls = 0;
	// answer bits change on falling clock; a released line never keeps its level
	always @(negedge sclk)
	begin
		falls = falls + 1;
		if (falls == 12)
		begin
			shOut = {8'h00, ackOk};
			case (shIn[11:8])
				4'h0: shOut = {cfg0, ackOk};
				4'h1: shOut = {cfg1, ackOk};
				4'h2: shOut = {STAT_VAL, ackOk};
				4'h3: shOut = {MON_VAL, ackOk};
				4'h8: cfg0 = shIn[7:0];
				default: cfg1 = shIn[7:0];
			endcase
		end
		if (falls >= 13 && falls <= 21)
		begin
			dout  = shOut[8];
			shOut = {shOut[7:0], 1'b0};
		end
		else
			dout = ~dout;
	end
endmodule // hvif_far_end
`default_nettype wire

// File: tb/hvif_core_asserts.sv
// port checker for the high-voltage indirect register interface
`include "hvif_defines.vh"
`default_nettype none
module hvif_core_asserts
#(
	parameter HALF_CYC = 24,
	parameter LAT_CYC  = 1250
)
(
	input wire logic        mclk,
	input wire logic        rst_n,
	input wire logic [31:0] regAddr,
	input wire logic        regWrEn,
	input wire logic        regRdEn,
	input wire logic [11:0] regWrData,
	input wire logic [11:0] regRdData,
	input wire logic        hvSclk,
	input wire logic        hvDataOut,
	input wire logic        hvDataOe,
	input wire logic        hvDataIn
);
	timeunit 1ns;
	timeprecision 1ps;
	localparam logic [31:0] CMD = `HVIF_CMD_ADDR;
	localparam logic [31:0] DAT = `HVIF_DAT_ADDR;
	localparam int          LIM = 60;
	logic sPrev = 1'b0;
	int   run   = 0;
	int   rises = 0;
	int   frm   = 0;
	logic cmdWr;
	logic valid;
	default clocking @(posedge mclk); endclocking
	default disable iff (!rst_n);
	// ----
	// helpers
	// ----
	assign cmdWr = regWrEn && regAddr == CMD;
	assign valid = regWrData[7:2] == 6'h00 || regWrData[7:1] == 7'h04;
	// phase length, bits per frame and frame age; frame age saturates at 5000 to stay bounded
	always @(posedge mclk)
	begin
		sPrev <= hvSclk;
		run   <= (hvSclk != sPrev) ? 1 : run + 1;
		rises <= !hvDataOe ? 0 : rises + int'(hvSclk && !sPrev);
		frm   <= $rose(hvDataOe) ? 1 : frm + int'(frm < 5000);
	end
	// ----
	// assertions
	// ----
	a_sclk_high: assert property ($fell(hvSclk) |-> run == HALF_CYC)
		else $error("serial clock high phase has wrong length");
	a_frame_start: assert property ($rose(hvDataOe) |-> !hvSclk ##[1:LIM] $rose(hvSclk))
		else $error("frame started without serial clock");
	a_out_steady: assert property (hvSclk && hvDataOe |-> $stable(hvDataOut))
		else $error("link data changed while clock high");
	a_twelve_bits: assert property ($fell(hvDataOe) |-> rises == 12)
		else $error("outbound frame not twelve bits");
	a_frame_bound: assert property ($rose(hvSclk) |-> frm <= LAT_CYC)
		else $error("frame ran past latency bound");
	a_busy_shown: assert property (regRdEn && regAddr == CMD && hvDataOe |=> regRdData[0])
		else $error("busy low during a frame");
	a_rsvd_zero: assert property (regRdEn && regAddr == CMD |=> regRdData[11:3] == 9'h000)
		else $error("reserved status bits set");
	a_unmapped: assert property (regRdEn && regAddr != CMD && regAddr != DAT
		|=> regRdData == 12'h000)
		else $error("unmapped read not zero");
	a_cmd_start: assert property (cmdWr && valid && !hvDataOe && !hvSclk |=> hvDataOe)
		else $error("valid command did not start a frame");
	a_bad_quiet: assert property (cmdWr && !valid && !hvDataOe |=> !hvDataOe ##1 !hvDataOe)
		else $error("unknown command drove the link");
	c_frame: cover property ($fell(hvDataOe));
	c_busy_read: cover property (regRdEn && regAddr == CMD && hvDataOe);
	c_bad_code: cover property (cmdWr && !valid);
endmodule // hvif_core_asserts
bind hvif_core hvif_core_asserts #(.HALF_CYC(HALF_CYC), .LAT_CYC(LAT_CYC)) chk_u
(
	.mclk(mclk), .rst_n(rst_n), .regAddr(regAddr), .regWrEn(regWrEn),
	.regRdEn(regRdEn), .regWrData(regWrData), .regRdData(regRdData),
	.hvSclk(hvSclk), .hvDataOut(hvDataOut), .hvDataOe(hvDataOe), .hvDataIn(hvDataIn)
);
`default_nettype wire

// File: tb/hvif_core_test.sv
// self-checking bench for the high-voltage indirect register interface
`include "hvif_defines.vh"
`default_nettype none
module hvif_core_test;
	timeunit 1ns;
	timeprecision 1ps;
	localparam logic [31:0] CMD = `HVIF_CMD_ADDR;
	localparam logic [31:0] DAT = `HVIF_DAT_ADDR;
	logic        mclk = 0, rst_n = 0, regWrEn = 0, regRdEn = 0, ackOk = 1;
	logic [31:0] regAddr = 0;
	logic [11:0] regWrData = 0, regRdData, v;
	logic        hvSclk, hvDataOut, hvDataOe, hvDataIn, farOut;
	int          fails = 0, checkCount = 0, cyc = 0, n;
	// ----
	// clock, shared wire, instances
	// ----
	always #4 mclk = ~mclk;
	assign hvDataIn = hvDataOe ? hvDataOut : farOut;
	// short half period gives a 160 ns link clock and a short run
	hvif_core #(.HALF_CYC(10), .LAT_CYC(600)) dut_u
	(
		.mclk(mclk), .rst_n(rst_n), .regAddr(regAddr), .regWrEn(regWrEn),
		.regRdEn(regRdEn), .regWrData(regWrData), .regRdData(regRdData),
		.hvSclk(hvSclk), .hvDataOut(hvDataOut), .hvDataOe(hvDataOe), .hvDataIn(hvDataIn)
	);
	hvif_far_end far_u
	(
		.sclk(hvSclk), .din(hvDataIn), .oe(hvDataOe), .ackOk(ackOk), .dout(farOut)
	);
	// ----
	// bus and compare tasks
	// ----
	task automatic check(input string what, input logic [11:0] seen, input logic [11:0] exp);
		checkCount++;
		if (seen !== exp)
		begin
			fails++;
			$display("unexpected %s: expected %h, seen %h", what, exp, seen);
		end
	endtask
	task automatic wr(input logic [31:0] a, input logic [11:0] d);
		@(negedge mclk);
		regAddr = a;
		regWrData = d;
		regWrEn = 1'b1;
		@(negedge mclk);
		regWrEn = 1'b0;
	endtask
	task automatic rd(input logic [31:0] a, output logic [11:0] d);
		@(negedge mclk);
		regAddr = a;
		regRdEn = 1'b1;
		@(negedge mclk);
		regRdEn = 1'b0;
		d = regRdData;
	endtask
	// polls busy with a bound, then judges status and data
	task automatic finish(input logic [11:0] st, input logic [11:0] dat);
		n = 0;
		do
		begin
			rd(CMD, v);
			n += 2;
		end while (v[0] !== 1'b0 && n < 2000);
		check("latency", 12'(n <= 1250), 12'h001);
		check("status", v, st);
		rd(DAT, v);
		check("data", v, dat);
	endtask
	task automatic cmd(input logic [7:0] c, input logic [11:0] st, input logic [11:0] dat);
		wr(CMD, {4'h0, c});
		finish(st, dat);
	endtask
	// ----
	// scenarios
	// ----
	task automatic t_reset;
		rd(CMD, v);
		check("status", v, 12'h000);
		rd(DAT, v);
		check("data", v, 12'h000);
		$display("reset values done");
	endtask
	// a data write during busy must not reach the far end
	task automatic t_write;
		wr(DAT, 12'h0a5);
		cmd(8'h08, 12'h004, 12'h8a5);
		wr(DAT, 12'h03c);
		wr(CMD, 12'h009);
		wr(DAT, 12'h0ff);
		finish(12'h004, 12'h93c);
		$display("config writes done");
	endtask
	task automatic t_read;
		logic [7:0] bytes [4] = '{8'ha5, 8'h3c, 8'h5a, 8'hc3};
		for (int i = 0; i < 4; i++)
			cmd(8'(i), 12'h006, {4'(i), bytes[i]});
		$display("indirect reads done");
	endtask
	task automatic t_fail;
		ackOk = 1'b0;
		cmd(8'h02, 12'h000, 12'h2c3);
		ackOk = 1'b1;
		cmd(8'h05, 12'h000, 12'h2c3);
		rd(32'hffff0808, v);
		check("unmapped", v, 12'h000);
		$display("failure and refusal done");
	endtask
	task automatic stopTest;
		$display("checks %0d, mismatches %0d", checkCount, fails);
		if (fails == 0 && checkCount > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	// ----
	// main sequence and hang guard
	// ----
	initial
	begin
		repeat (5) @(negedge mclk);
		rst_n = 1'b1;
		t_reset;
		t_write;
		t_read;
		t_fail;
		stopTest;
	end
	// seven frames need about 3200 cycles; the ceiling leaves room
	always @(posedge mclk)
	begin
		cyc++;
		if (cyc == 20000)
		begin
			fails++;
			stopTest;
		end
	end
endmodule // hvif_core_test
`default_nettype wire
